// *** inc/cwrf_regs.svh ***
// Constants for the working register file
//
// Overview of operation
// - The file holds thirty-two registers of eight bits, each readable or writable in one cycle.
// - In one cycle the file gives two source operands and takes the result into a destination.
// - Six registers pair up into three 16-bit indirect pointers for data-space addressing.
// - One of the three pointers also gives the program-memory address for constant lookups.
// - Data-space addresses 0x00 to 0x1F read or write the matching working register.
// - The file feeds register pairs, register plus immediate and single-register operations.
// - Data-space addresses 0x20 to 0x5F select the I/O space instead of the registers.
`ifndef CWRF_REGS_SVH
`define CWRF_REGS_SVH
`define CWRF_NUM_REGS     32
`define CWRF_REG_W        8
`define CWRF_RESET_VAL    8'h00
`define CWRF_PTR_X_LO     5'h1A
`define CWRF_PTR_Y_LO     5'h1C
`define CWRF_PTR_Z_LO     5'h1E
`define CWRF_REG_TOP      16'h001F
`define CWRF_IO_BASE      16'h0020
`define CWRF_IO_TOP       16'h005F
`define CWRF_ADDR_W       16
`endif

// *** inc/cwrf_pkg.sv ***
// Types for the working register file
package cwrf_pkg;
    typedef enum logic [1:0] {
        CWRF_OP_REG_REG,
        CWRF_OP_REG_IMM,
        CWRF_OP_SINGLE,
        CWRF_OP_NONE
    } cwrf_op_t;

    typedef struct packed {
        cwrf_op_t   op;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [7:0] imm;
    } cwrf_rd_req_t;

    typedef struct packed {
        logic       en;
        logic [4:0] dst;
        logic [7:0] data;
    } cwrf_wb_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cwrf_ds_req_t;
endpackage

// *** verilog/cwrf_ds_decode.sv ***
// Data-space address decoder for the working register file
`timescale 1ns/1ps
`default_nettype none
`include "cwrf_regs.svh"
module cwrf_ds_decode (
    input  wire logic [15:0] i_addr,
    output logic             o_is_reg,
    output logic             o_is_io
);
    always_comb begin
        o_is_reg = (i_addr <= `CWRF_REG_TOP);
        o_is_io  = (i_addr >= `CWRF_IO_BASE) && (i_addr <= `CWRF_IO_TOP);
    end
endmodule
`default_nettype wire

// *** verilog/cwrf_top.sv ***
// Working register file top with ALU, data-space and pointer ports
`timescale 1ns/1ps
`default_nettype none
`include "cwrf_regs.svh"
module cwrf_top #(
    parameter int NUM_REGS = `CWRF_NUM_REGS,
    parameter int REG_W    = `CWRF_REG_W
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_ce,
    input  wire cwrf_pkg::cwrf_rd_req_t i_rd_req,
    input  wire cwrf_pkg::cwrf_wb_t    i_wb,
    input  wire cwrf_pkg::cwrf_ds_req_t i_ds_req,
    output logic [7:0]                 o_opnd_a,
    output logic [7:0]                 o_opnd_b,
    output logic [7:0]                 o_ds_rdata,
    output logic                       o_ds_rvalid,
    output logic                       o_io_sel,
    output logic [15:0]                o_ptr_x,
    output logic [15:0]                o_ptr_y,
    output logic [15:0]                o_ptr_z,
    output logic [15:0]                o_lpm_addr
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int PTR_W = 2 * REG_W;

    localparam logic [4:0] PTR_LO [0:2] = '{
        `CWRF_PTR_X_LO,
        `CWRF_PTR_Y_LO,
        `CWRF_PTR_Z_LO
    };

    if (NUM_REGS != `CWRF_NUM_REGS) begin : g_bad_num
        $error("cwrf_top serves exactly 32 working registers");
    end
    if (REG_W != `CWRF_REG_W) begin : g_bad_width
        $error("cwrf_top serves only 8-bit working registers");
    end
    if (PTR_W != `CWRF_ADDR_W) begin : g_bad_ptr
        $error("cwrf_top pointers must span the data space");
    end

    // Each pointer pair must start on an even register
    for (genvar p = 0; p < 3; p++) begin : g_ptr_chk
        if (PTR_LO[p][0] != 1'b0) begin : g_odd
            $error("cwrf_top pointer low byte must be an even register");
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [REG_W-1:0] regs      [0:NUM_REGS-1];
    logic [REG_W-1:0] next_regs [0:NUM_REGS-1];

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Register index of a data-space address
    function automatic logic [4:0] ds_index(
        input logic [15:0] addr
    );
        ds_index = addr[4:0];
    endfunction

    // Pointer from an even register and the odd one above it
    function automatic logic [15:0] pair(
        input logic [4:0]       lo,
        input logic [REG_W-1:0] r [0:NUM_REGS-1]
    );
        logic [4:0] hi;
        hi   = lo | 5'h01;
        pair = {r[hi], r[lo]};
    endfunction

    // Second operand per operation class
    function automatic logic [7:0] pick_b(
        input cwrf_pkg::cwrf_op_t op,
        input logic [7:0]         reg_b,
        input logic [7:0]         imm
    );
        unique case (op)
            cwrf_pkg::CWRF_OP_REG_REG: pick_b = reg_b;
            cwrf_pkg::CWRF_OP_REG_IMM: pick_b = imm;
            cwrf_pkg::CWRF_OP_SINGLE:  pick_b = `CWRF_RESET_VAL;
            cwrf_pkg::CWRF_OP_NONE:    pick_b = `CWRF_RESET_VAL;
        endcase
    endfunction

    logic is_reg;
    logic is_io;

    cwrf_ds_decode u_dec (
        .i_addr   (i_ds_req.addr),
        .o_is_reg (is_reg),
        .o_is_io  (is_io)
    );

    // ------------------------------------------------------------
    // Write-back: ALU result wins over a data-space store
    // ------------------------------------------------------------
    logic       ds_store;
    logic [4:0] ds_idx;

    always_comb begin
        ds_store = i_ds_req.wr && is_reg;
        ds_idx   = ds_index(i_ds_req.addr);
        for (int i = 0; i < NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        if (ds_store) begin
            next_regs[ds_idx] = i_ds_req.wdata;
        end
        // Applied last so a same-cycle store to that register loses
        if (i_wb.en) begin
            next_regs[i_wb.dst] = i_wb.data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    regs[g] <= `CWRF_RESET_VAL;
                end else if (i_ce) begin
                    regs[g] <= next_regs[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Operand outputs
    // ------------------------------------------------------------
    // Reads see the value before this edge: no write bypass
    logic [7:0] next_opnd_a;
    logic [7:0] next_opnd_b;

    always_comb begin
        next_opnd_a = regs[i_rd_req.src_a];
        next_opnd_b = pick_b(i_rd_req.op, regs[i_rd_req.src_b],
                             i_rd_req.imm);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_opnd_a <= `CWRF_RESET_VAL;
            o_opnd_b <= `CWRF_RESET_VAL;
        end else if (i_ce) begin
            o_opnd_a <= next_opnd_a;
            o_opnd_b <= next_opnd_b;
        end
    end

    // ------------------------------------------------------------
    // Data-space outputs
    // ------------------------------------------------------------
    logic [7:0] next_ds_rdata;
    logic       next_ds_rvalid;
    logic       next_io_sel;

    always_comb begin
        next_ds_rvalid = i_ds_req.rd && is_reg;
        next_ds_rdata  = next_ds_rvalid ? regs[ds_index(i_ds_req.addr)]
                                        : `CWRF_RESET_VAL;
        next_io_sel    = (i_ds_req.rd || i_ds_req.wr) && is_io;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ds_rdata  <= `CWRF_RESET_VAL;
            o_ds_rvalid <= 1'b0;
            o_io_sel    <= 1'b0;
        end else if (i_ce) begin
            o_ds_rdata  <= next_ds_rdata;
            o_ds_rvalid <= next_ds_rvalid;
            o_io_sel    <= next_io_sel;
        end
    end

    // ------------------------------------------------------------
    // Pointer outputs
    // ------------------------------------------------------------
    // Built from next_regs so a pointer shows this edge's writes
    logic [15:0] next_ptr_x;
    logic [15:0] next_ptr_y;
    logic [15:0] next_ptr_z;
    logic [15:0] next_lpm_addr;

    always_comb begin
        next_ptr_x    = pair(`CWRF_PTR_X_LO, next_regs);
        next_ptr_y    = pair(`CWRF_PTR_Y_LO, next_regs);
        next_ptr_z    = pair(`CWRF_PTR_Z_LO, next_regs);
        next_lpm_addr = next_ptr_z;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ptr_x    <= {2{`CWRF_RESET_VAL}};
            o_ptr_y    <= {2{`CWRF_RESET_VAL}};
            o_ptr_z    <= {2{`CWRF_RESET_VAL}};
            o_lpm_addr <= {2{`CWRF_RESET_VAL}};
        end else if (i_ce) begin
            o_ptr_x    <= next_ptr_x;
            o_ptr_y    <= next_ptr_y;
            o_ptr_z    <= next_ptr_z;
            o_lpm_addr <= next_lpm_addr;
        end
    end
endmodule
`default_nettype wire

// *** bench/cwrf_top_asserts.sv ***
// Port checker for the working register file
`timescale 1ns/1ps
`default_nettype none
module cwrf_asserts (
    input wire logic                   i_ref_clk,
    input wire logic                   i_rst_n,
    input wire logic                   i_ce,
    input wire cwrf_pkg::cwrf_rd_req_t i_rd_req,
    input wire cwrf_pkg::cwrf_wb_t     i_wb,
    input wire cwrf_pkg::cwrf_ds_req_t i_ds_req,
    input wire logic [7:0]             o_opnd_a,
    input wire logic [7:0]             o_opnd_b,
    input wire logic                   o_ds_rvalid,
    input wire logic                   o_io_sel,
    input wire logic [15:0]            o_ptr_x,
    input wire logic [15:0]            o_ptr_z,
    input wire logic [15:0]            o_lpm_addr
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic w  = i_ce && i_wb.en;
    wire logic rq = i_ce && i_ds_req.rd && i_ds_req.addr <= 16'h001f;
    wire logic io = i_ds_req.addr inside {[16'h0020:16'h005f]};
    lpm_z_a: assert property (o_lpm_addr == o_ptr_z) else $error("lpm");
    rd_ok_a: assert property (rq |=> o_ds_rvalid) else $error("rv");
    io_on_a: assert property (i_ce && io && (i_ds_req.rd || i_ds_req.wr)
        |=> o_io_sel) else $error("io on");
    io_off_a: assert property (i_ce && !io |=> !o_io_sel) else $error("io");
    imm_b_a: assert property (i_ce && i_rd_req.op == cwrf_pkg::CWRF_OP_REG_IMM
        |=> o_opnd_b == $past(i_rd_req.imm)) else $error("imm");
    one_b_a: assert property (i_ce && i_rd_req.op == cwrf_pkg::CWRF_OP_SINGLE
        |=> o_opnd_b == 8'h00) else $error("single");
    ptr_z_a: assert property (w && i_wb.dst == 5'h1e
        |=> o_ptr_z[7:0] == $past(i_wb.data)) else $error("z");
    ptr_x_a: assert property (w && i_wb.dst == 5'h1b
        |=> o_ptr_x[15:8] == $past(i_wb.data)) else $error("x");
    hold_a: assert property (!i_ce |=> $stable(o_opnd_a)) else $error("ce");
    cover property (w ##1 rq);
    cover property (i_ce && io ##1 o_io_sel);
    cover property (!i_ce);
endmodule
bind cwrf_top cwrf_asserts u_cwrf_asserts (.*);
`default_nettype wire

// *** bench/cwrf_alu_model.sv ***
// Behavioural ALU and load path feeding write-back
`timescale 1ns/1ps
`default_nettype none
module cwrf_alu_model (
    input  wire logic               i_alu,
    input  wire cwrf_pkg::cwrf_wb_t i_req,
    input  wire logic [7:0]         i_opnd_a,
    input  wire logic [7:0]         i_opnd_b,
    output var cwrf_pkg::cwrf_wb_t  o_wb
);
    // Operand sum or a plain load value
    assign o_wb = '{i_req.en, i_req.dst,
                    i_alu ? i_opnd_a + i_opnd_b : i_req.data};
endmodule
`default_nettype wire

// *** bench/tb_cwrf_top.sv ***
// Self-checking bench for the working register file
`timescale 1ns/1ps
`default_nettype none
module tb_cwrf_top;
    logic                   i_ref_clk = 1'b0;
    logic                   i_rst_n = 1'b0;
    logic                   i_ce = 1'b1;
    logic                   alu = 1'b0;
    cwrf_pkg::cwrf_wb_t     wq = '0;
    cwrf_pkg::cwrf_wb_t     i_wb;
    cwrf_pkg::cwrf_rd_req_t i_rd_req = '0;
    cwrf_pkg::cwrf_ds_req_t i_ds_req = '0;
    logic [7:0]             o_opnd_a, o_opnd_b, o_ds_rdata;
    logic                   o_ds_rvalid, o_io_sel;
    logic [15:0]            o_ptr_x, o_ptr_y, o_ptr_z, o_lpm_addr;
    int                     bad_count = 0;
    int                     comparisons = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    cwrf_top u_cwrf_top (.*);
    cwrf_alu_model u_cwrf_alu_model (.i_alu(alu), .i_req(wq),
        .i_opnd_a(o_opnd_a), .i_opnd_b(o_opnd_b), .o_wb(i_wb));
    task automatic stp; @(posedge i_ref_clk); #1; endtask
    function automatic logic [7:0] v(input int i); return 8'hc0 | 8'(i);
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic t_regs;
        for (int i = 0; i < 32; i++) begin
            wq = '{1'b1, 5'(i), v(i)};
            stp;
        end
        wq = '0;
        for (int i = 0; i < 32; i++) begin
            i_rd_req = '{cwrf_pkg::CWRF_OP_REG_REG, 5'(i), 5'(31 - i), 8'h00};
            i_ds_req = '{1'b1, 1'b0, 16'(i), 8'h00};
            stp;
            chk(o_opnd_a, v(i));
            chk(o_opnd_b, v(31 - i));
            chk(o_ds_rdata, v(i));
            chk(o_ds_rvalid, 1'b1);
        end
        chk(o_ptr_x, 16'hdbda);
        chk(o_ptr_z, 16'hdfde);
        chk(o_ptr_y, 16'hdddc);
        chk(o_lpm_addr, 16'hdfde);
        $display("t_regs done");
    endtask
    task automatic t_alu;
        i_rd_req = '{cwrf_pkg::CWRF_OP_REG_IMM, 5'h01, 5'h00, 8'h11};
        stp;
        chk(o_opnd_b, 8'h11);
        alu = 1'b1;
        wq = '{1'b1, 5'h02, 8'h00};
        i_rd_req = '{cwrf_pkg::CWRF_OP_SINGLE, 5'h02, 5'h00, 8'h00};
        stp;
        chk(o_opnd_a, v(2));
        alu = 1'b0;
        wq = '0;
        stp;
        chk(o_opnd_a, 8'hd2);
        $display("t_alu done");
    endtask
    task automatic t_ds;
        i_ds_req = '{1'b0, 1'b1, 16'h0003, 8'h5a};
        stp;
        i_ds_req = '{1'b0, 1'b1, 16'h0043, 8'ha5};
        stp;
        chk(o_io_sel, 1'b1);
        i_ds_req = '{1'b1, 1'b0, 16'h0003, 8'h00};
        stp;
        chk(o_ds_rdata, 8'h5a);
        i_ce = 1'b0;
        i_rd_req.src_a = 5'h03;
        stp;
        chk(o_opnd_a, 8'hd2);
        i_ce = 1'b1;
        wq = '{1'b1, 5'h04, 8'h77};
        i_ds_req = '{1'b0, 1'b1, 16'h0004, 8'h33};
        stp;
        wq = '0;
        i_ds_req = '{1'b1, 1'b0, 16'h0004, 8'h00};
        stp;
        chk(o_ds_rdata, 8'h77);
        chk(o_io_sel, 1'b0);
        $display("t_ds done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) stp;
        i_rst_n = 1'b1;
        t_regs;
        t_alu;
        t_ds;
        wrap_up;
    end
    initial begin
        #(400 * 5);
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
